// ### rtl/adc_chan_pkg.sv
package adc_chan_pkg;
	// ==========================================
	// Register map (link addresses)
	localparam logic [6:0] ADDR_COMMAND = 7'h20;
	localparam logic [6:0] ADDR_STATUS = 7'h21;
	localparam logic [6:0] ADDR_RESULT = 7'h23;
	// ==========================================
	// Field layout and codes
	localparam int REG_W = 24;
	localparam int MODE_LSB = 20;
	localparam int RATE_LSB = 16;
	localparam logic [1:0] MODE_POWERDOWN = 2'h1;
	localparam logic [1:0] MODE_CONVERT = 2'h3;
	localparam logic [1:0] MODE_RESET = MODE_POWERDOWN;
	localparam logic [3:0] RATE_RESET = 4'h0;
	localparam logic [1:0] PD_CONVERTING = 2'h0;
	localparam logic [1:0] PD_STANDBY = 2'h2;
	localparam logic [1:0] PD_IN_RESET = 2'h3;
	localparam logic [1:0] PD_RESET = PD_STANDBY;
	// ==========================================
	// Status word bit positions
	localparam int STA_READY = 0;
	localparam int STA_MODULATOR = 1;
	localparam int STA_PD_LSB = 2;
	localparam int STA_RATE_LSB = 4;
	localparam int STA_ANALOG_OR = 8;
	localparam int STA_DIGITAL_OR = 9;
	localparam int STA_REFERENCE = 14;
	// ==========================================
	// Link frame
	localparam int HDR_BITS = 8;
	localparam int FRAME_BITS = 32;
	localparam logic [5:0] HDR_LAST = 6'h07;
	localparam logic [5:0] FRAME_LAST = 6'h1F;
	localparam logic [5:0] DATA_FIRST = 6'h08;
endpackage

// ### rtl/link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface link_if;
	logic wrPulse;
	logic rdPulse;
	logic [6:0] addr;
	logic [23:0] wdata;
	logic [23:0] rdata;
	modport link(output wrPulse, output rdPulse, output addr, output wdata, input rdata);
	modport regs(input wrPulse, input rdPulse, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### rtl/spi_link_slave.sv
`timescale 1ns/1ps
`default_nettype none
module spi_link_slave import adc_chan_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link pins
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	output logic miso,
	output logic misoEn,
	// Register side
	link_if.link lnk
);
	typedef struct packed {
		logic sclk1;
		logic sclk2;
		logic sclkPrev;
		logic cs1;
		logic cs2;
		logic mosi1;
		logic mosi2;
		logic [5:0] bitCount;
		logic [31:0] shiftIn;
		logic [23:0] shiftOut;
		logic isRead;
		logic loadArm;
		logic loadPending;
		logic misoOut;
		logic misoDrive;
		logic [6:0] addr;
		logic wrPulse;
		logic rdPulse;
		logic [23:0] wdata;
	} link_state_t;

	link_state_t st;
	link_state_t next_st;

	// ==========================================
	// Frame shifter
	always_comb begin
		logic [7:0] header;
		header = 8'h00;
		next_st = st;
		next_st.sclk1 = sclk;
		next_st.sclk2 = st.sclk1;
		next_st.sclkPrev = st.sclk2;
		next_st.cs1 = csN;
		next_st.cs2 = st.cs1;
		next_st.mosi1 = mosi;
		next_st.mosi2 = st.mosi1;
		next_st.wrPulse = 1'b0;
		next_st.rdPulse = 1'b0;
		if (st.loadPending) begin
			next_st.shiftOut = lnk.rdata;
			next_st.loadPending = 1'b0;
		end
		// Read data settles one clock after the read pulse
		if (st.loadArm) begin
			next_st.loadArm = 1'b0;
			next_st.loadPending = 1'b1;
		end
		if (st.cs2) begin
			next_st.bitCount = 6'h00;
			next_st.misoDrive = 1'b0;
			next_st.misoOut = 1'b0;
		end else begin
			next_st.misoDrive = 1'b1;
			if (st.sclk2 && !st.sclkPrev) begin
				next_st.shiftIn = {st.shiftIn[30:0], st.mosi2};
				next_st.bitCount = st.bitCount + 6'h01;
				if (st.bitCount == HDR_LAST) begin
					header = {st.shiftIn[6:0], st.mosi2};
					next_st.addr = header[7:1];
					next_st.isRead = header[0];
					next_st.rdPulse = header[0];
					next_st.loadArm = header[0];
				end
				if (st.bitCount == FRAME_LAST && !st.isRead) begin
					next_st.wrPulse = 1'b1;
					next_st.wdata = {st.shiftIn[22:0], st.mosi2};
				end
			end
			if (!st.sclk2 && st.sclkPrev && st.isRead && st.bitCount >= DATA_FIRST) begin
				next_st.misoOut = st.shiftOut[23];
				next_st.shiftOut = {st.shiftOut[22:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.cs1 <= 1'b1;
			st.cs2 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign miso = st.misoOut;
	assign misoEn = st.misoDrive;
	assign lnk.wrPulse = st.wrPulse;
	assign lnk.rdPulse = st.rdPulse;
	assign lnk.addr = st.addr;
	assign lnk.wdata = st.wdata;
endmodule
`default_nettype wire

// ### rtl/adc_channel_command_status.sv
`timescale 1ns/1ps
`default_nettype none
module adc_channel_command_status import adc_chan_pkg::*; #(
	parameter int RAW_W = 26
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link pins
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	output logic miso,
	output logic misoEn,
	// Converter core
	input wire logic sampleValid,
	input wire logic signed [RAW_W-1:0] rawResult,
	input wire logic analogOverrange,
	input wire logic modulatorActive,
	input wire logic adcInReset,
	input wire logic referencePresent,
	// Converter control
	output logic convertEnable,
	output logic powerDown,
	output logic [3:0] rateCode
);
	// ==========================================
	// Result limits
	localparam logic signed [RAW_W-1:0] RESULT_MAX = RAW_W'(24'sh7FFFFF);
	localparam logic signed [RAW_W-1:0] RESULT_MIN = -RAW_W'(24'sh7FFFFF) - RAW_W'(1);

	// ==========================================
	// Register state
	typedef struct packed {
		logic [1:0] adcOpModeField;
		logic [3:0] adcRateCode;
		logic [23:0] adcResultRegister;
		logic resultReady;
		logic modulatorActiveFlag;
		logic [1:0] powerdownStateField;
		logic [3:0] resultRate;
		logic analogOverrangeFlag;
		logic digitalOverrangeFlag;
		logic referencePresentFlag;
		logic [23:0] readData;
		logic convertOut;
		logic powerDownOut;
	} regs_state_t;

	regs_state_t st;
	regs_state_t next_st;
	link_if bus();

	// ==========================================
	// Field helpers
	// status word layout
	function automatic logic [REG_W-1:0] pack_status(input regs_state_t s);
		logic [REG_W-1:0] w;
		w = '0;
		w[STA_READY] = s.resultReady;
		w[STA_MODULATOR] = s.modulatorActiveFlag;
		w[STA_PD_LSB+1:STA_PD_LSB] = s.powerdownStateField;
		w[STA_RATE_LSB+3:STA_RATE_LSB] = s.resultRate;
		w[STA_ANALOG_OR] = s.analogOverrangeFlag;
		w[STA_DIGITAL_OR] = s.digitalOverrangeFlag;
		w[STA_REFERENCE] = s.referencePresentFlag;
		return w;
	endfunction

	function automatic logic [REG_W-1:0] pack_command(input regs_state_t s);
		logic [REG_W-1:0] w;
		w = '0;
		w[MODE_LSB+1:MODE_LSB] = s.adcOpModeField;
		w[RATE_LSB+3:RATE_LSB] = s.adcRateCode;
		return w;
	endfunction

	// ==========================================
	// Decode helpers
	// powerdown state encoding
	function automatic logic [1:0] pd_state(input logic inReset, input logic active);
		logic [1:0] code;
		if (inReset) begin
			code = PD_IN_RESET;
		end else if (active) begin
			code = PD_CONVERTING;
		end else begin
			code = PD_STANDBY;
		end
		return code;
	endfunction

	function automatic logic [REG_W-1:0] clamp_result(input logic signed [RAW_W-1:0] value);
		logic [REG_W-1:0] r;
		if (value > RESULT_MAX) begin
			r = RESULT_MAX[REG_W-1:0];
		end else if (value < RESULT_MIN) begin
			r = RESULT_MIN[REG_W-1:0];
		end else begin
			r = value[REG_W-1:0];
		end
		return r;
	endfunction

	// only the two defined mode codes
	function automatic logic mode_legal(input logic [1:0] m);
		return (m == MODE_POWERDOWN) || (m == MODE_CONVERT);
	endfunction

	// ==========================================
	// Link shifter
	spi_link_slave linkSlave (
		.clk(clk),
		.srst(srst),
		.sclk(sclk),
		.csN(csN),
		.mosi(mosi),
		.miso(miso),
		.misoEn(misoEn),
		.lnk(bus.link)
	);

	// ==========================================
	// Register behaviour
	always_comb begin
		logic [1:0] wrMode;
		logic commandWrite;
		logic resultRead;
		logic outOfRange;
		logic [REG_W-1:0] statusWord;
		logic [REG_W-1:0] commandWord;
		logic [REG_W-1:0] clamped;
		wrMode = bus.wdata[MODE_LSB+1:MODE_LSB];
		commandWrite = bus.wrPulse && (bus.addr == ADDR_COMMAND);
		resultRead = bus.rdPulse && (bus.addr == ADDR_RESULT);
		outOfRange = (rawResult > RESULT_MAX) || (rawResult < RESULT_MIN);
		statusWord = pack_status(st);
		commandWord = pack_command(st);
		clamped = clamp_result(rawResult);
		next_st = st;
		// Command write, rate part always taken
		if (commandWrite) begin
			next_st.adcRateCode = bus.wdata[RATE_LSB+3:RATE_LSB];
			if (!modulatorActive && mode_legal(wrMode)) begin
				next_st.adcOpModeField = wrMode;
			end
		end
		// Read data snapshot at header time
		if (bus.rdPulse) begin
			case (bus.addr)
				ADDR_COMMAND: begin
					next_st.readData = commandWord;
				end
				ADDR_STATUS: begin
					next_st.readData = statusWord;
				end
				ADDR_RESULT: begin
					next_st.readData = st.adcResultRegister;
				end
				default: begin
					next_st.readData = 24'h000000;
				end
			endcase
		end
		if (resultRead) begin
			next_st.resultReady = 1'b0;
		end
		if (sampleValid) begin
			next_st.resultReady = 1'b1;
			next_st.modulatorActiveFlag = modulatorActive;
			next_st.referencePresentFlag = referencePresent;
			next_st.resultRate = st.adcRateCode;
			next_st.analogOverrangeFlag = analogOverrange;
			next_st.digitalOverrangeFlag = outOfRange;
			next_st.adcResultRegister = clamped;
			next_st.powerdownStateField = pd_state(adcInReset, modulatorActive);
		end
		next_st.convertOut = (next_st.adcOpModeField == MODE_CONVERT);
		next_st.powerDownOut = (next_st.adcOpModeField == MODE_POWERDOWN);
	end

	// ==========================================
	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.adcOpModeField <= MODE_RESET;
			st.powerDownOut <= 1'b1;
			st.adcRateCode <= RATE_RESET;
			st.powerdownStateField <= PD_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs
	assign bus.rdata = st.readData;
	assign convertEnable = st.convertOut;
	assign powerDown = st.powerDownOut;
	assign rateCode = st.adcRateCode;
endmodule
`default_nettype wire

// ### sim/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Link pins
	output logic sclk,
	output logic csN,
	output logic mosi,
	input wire logic miso
);
	// ======
	// Frame master, clock idles low
	initial {sclk, csN, mosi} = 3'h2;
	task automatic frame(input logic [31:0] tx, output logic [23:0] rx);
		csN = 0;
		for (int i = 31; i >= 0; i--) begin
			mosi = tx[i];
			#200 sclk = 1;
			if (i < 24) rx[i] = miso;
			#200 sclk = 0;
		end
		#200 csN = 1;
		mosi = ~mosi;
		#400;
	endtask
endmodule
`default_nettype wire

// ### sim/adc_channel_command_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adc_channel_command_status_chk import adc_chan_pkg::*; (
	// Watched ports
	input wire logic clk,
	input wire logic srst,
	input wire logic csN,
	input wire logic miso,
	input wire logic misoEn,
	input wire logic modulatorActive,
	input wire logic convertEnable,
	input wire logic powerDown,
	input wire logic [3:0] rateCode
);
	// ======
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_busy; modulatorActive [*3]; endsequence
	sequence s_idle; csN [*8]; endsequence
	a_mode_exclusive: assert property (convertEnable ^ powerDown) else $error("mode");
	a_reset_mode: assert property ($past(srst) |-> powerDown) else $error("rst mode");
	a_reset_rate: assert property ($past(srst) |-> rateCode == RATE_RESET) else $error("rate");
	a_reset_link: assert property ($past(srst) |-> !misoEn && !miso) else $error("link");
	a_mode_frozen: assert property (s_busy |=> $stable(convertEnable)) else $error("busy");
	a_idle_stable: assert property (s_idle |=> $stable({rateCode, powerDown})) else $error("idle");
	a_en_idle: assert property (csN [*4] |=> !misoEn) else $error("en idle");
	a_en_frame: assert property (!csN [*4] |=> misoEn) else $error("en frame");
endmodule
bind adc_channel_command_status adc_channel_command_status_chk chk (.clk(clk), .srst(srst),
	.csN(csN), .miso(miso), .misoEn(misoEn), .modulatorActive(modulatorActive),
	.convertEnable(convertEnable), .powerDown(powerDown), .rateCode(rateCode));
`default_nettype wire

// ### sim/adc_channel_command_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_channel_command_status_tb;
	import adc_chan_pkg::*;
	// ======
	// Stimulus and model state
	logic clk = 0, srst = 1, sv = 0, analog_overrange_flag = 0, mAct = 0, aRst = 0, refOk = 0;
	logic signed [25:0] raw = '0, v;
	logic signed [25:0] vals [4] = '{26'sh0800000, -26'sh0800001, 26'sh07FFFFF, -26'sh0800000};
	wire logic sclk, csN, mosi, miso, misoEn, convEn, pDown;
	wire logic [3:0] rateCode;
	wire logic misoW = misoEn ? miso : 1'b1;
	logic [23:0] rd, expStat, expRes;
	logic [1:0] mode = MODE_RESET;
	logic [3:0] rate = RATE_RESET;
	int bad_count = 0, total_checks = 0, cycles = 0, seed = 8082;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			end_sim();
		end
	end
	spi_host_model host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(misoW));
	adc_channel_command_status dut (.clk(clk), .srst(srst), .sclk(sclk), .csN(csN), .mosi(mosi),
		.miso(miso), .misoEn(misoEn), .sampleValid(sv), .rawResult(raw),
		.analogOverrange(analog_overrange_flag), .modulatorActive(mAct), .adcInReset(aRst),
		.referencePresent(refOk), .convertEnable(convEn), .powerDown(pDown), .rateCode(rateCode));
	task automatic check(input string what, input logic [23:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic xfer(input logic [6:0] a, input logic w, input logic [23:0] d);
		host.frame({a, ~w, d}, rd);
	endtask
	task automatic wrCmd(input logic [1:0] m, input logic [3:0] r);
		xfer(ADDR_COMMAND, 1, {2'h0, m, r, 16'h0});
		rate = r;
		if (!mAct && m[0]) mode = m;
		check("ctrl", {pDown, convEn, rateCode}, {mode == MODE_POWERDOWN, mode == MODE_CONVERT, r});
		xfer(ADDR_COMMAND, 0, 24'h0);
		check("cmd", rd, {2'h0, mode, rate, 16'h0});
	endtask
	task automatic sample();
		@(negedge clk);
		raw = v;
		sv = 1;
		{analog_overrange_flag, mAct, aRst, refOk} = 4'($random(seed));
		expRes = v > 26'sh07FFFFF ? 24'h7FFFFF : v < -26'sh0800000 ? 24'h800000 : v[23:0];
		expStat = {9'h0, refOk, 4'h0, (v > 26'sh07FFFFF || v < -26'sh0800000), analog_overrange_flag, rate,
			aRst ? PD_IN_RESET : mAct ? PD_CONVERTING : PD_STANDBY, mAct, 1'b1};
		@(negedge clk);
		sv = 0;
		{analog_overrange_flag, aRst, refOk} = ~{analog_overrange_flag, aRst, refOk};
		xfer(ADDR_STATUS, 0, 24'h0);
		check("status", rd, expStat);
		xfer(ADDR_RESULT, 0, 24'h0);
		check("result", rd, expRes);
	endtask
	initial begin
		repeat (3) @(negedge clk);
		srst = 0;
		repeat (3) @(negedge clk);
		check("outs", {pDown, convEn, rateCode}, 24'h20);
		xfer(ADDR_STATUS, 0, 24'h0);
		check("stat0", rd, 24'h000008);
		xfer(7'h55, 0, 24'h0);
		check("none", rd, 24'h0);
		wrCmd(2'h0, 4'h5);
		for (int i = 0; i < 12; i++) begin
			v = i > 7 ? 26'($signed(24'($random(seed)))) : vals[i % 4];
			wrCmd(2'($random(seed)), 4'($random(seed)));
			sample();
			xfer(ADDR_STATUS, 1, 24'hFFFFFF);
			wrCmd(2'($random(seed)), 4'($random(seed)));
			xfer(ADDR_STATUS, 0, 24'h0);
			check("kept", rd, expStat & 24'hFFFFFE);
		end
		end_sim();
	end
endmodule
`default_nettype wire
